/* File: rtl/vds_pkg.sv */
/*
  Constants for the video decoder sync control block: register subaddresses,
  field positions, reset values and horizontal counter geometry.
  Assumes one system clock with a line-locked clock enable pulse.
*/
`default_nettype none

package vds_pkg;

  // ****************************************
  // Register subaddresses
  // ****************************************
  localparam logic [7:0] ADDR_HS_START = 8'h06;
  localparam logic [7:0] ADDR_HS_STOP = 8'h07;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h08;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_HS_START = 8'h00;
  localparam logic [7:0] RST_HS_STOP = 8'h00;
  // Recommended: automatic field detection, fast locking, normal noise mode
  localparam logic [7:0] RST_SYNC_CTRL = 8'h98;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ****************************************
  // Sync control field positions
  // ****************************************
  localparam int BIT_AUTO_FIELD = 7;
  localparam int BIT_FIELD_SEL = 6;
  localparam int BIT_FORCE_TOGGLE = 5;
  localparam int HTC_HI = 4;
  localparam int HTC_LO = 3;
  localparam int BIT_LOOP_OPEN = 2;
  localparam int VERT_NOISE_MODE_HI = 1;
  localparam int VERT_NOISE_MODE_LO = 0;

  // ****************************************
  // Mode encodings
  // ****************************************
  localparam logic [1:0] HTC_TV = 2'h0;
  localparam logic [1:0] HTC_VTR = 2'h1;
  localparam logic [1:0] HTC_RSVD = 2'h2;
  localparam logic [1:0] HTC_FAST = 2'h3;
  localparam logic [1:0] VERT_NOISE_MODE_NORMAL = 2'h0;
  localparam logic [1:0] VERT_NOISE_MODE_FAST = 2'h1;
  localparam logic [1:0] VERT_NOISE_MODE_FREE = 2'h2;
  localparam logic [1:0] VERT_NOISE_MODE_BYPASS = 2'h3;

  // ****************************************
  // Horizontal counter geometry, in line-locked clock cycles
  // ****************************************
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] LINE_LEN_50 = 12'h800;
  localparam logic [CNT_W-1:0] LINE_LEN_60 = 12'h7d0;
  localparam logic [CNT_W-1:0] HS_CENTER = 12'h3e8;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_TWO = 12'h002;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  // Delay step is 8 line-locked clocks: sign extend, then shift by three
  function automatic logic [CNT_W-1:0] delay_pos(input logic [CNT_W-1:0] center, input logic [7:0] delay);
    logic [CNT_W-1:0] offs;
    offs = {delay[7], delay, 3'h0};
    return center + offs;
  endfunction

endpackage

`default_nettype wire

/* File: rtl/vds_hsync_gen.sv */
/*
  Horizontal line counter and sync pulse placement on the line-locked clock.
  Assumes llc_en is a one-cycle enable and all inputs are synchronous.
*/
`default_nettype none

module vds_hsync_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Line-locked clock enable and configuration
  input wire logic llc_en,
  input wire logic std_60,
  input wire logic loop_open,
  input wire logic [1:0] time_const,
  input wire logic [7:0] start_delay,
  input wire logic [7:0] stop_delay,
  // Reference sync from the slicer
  input wire logic ref_pulse,
  // Results
  output logic hsync_q,
  output logic [vds_pkg::CNT_W-1:0] count_q
);

  // ****************************************
  // Counter and pulse
  // ****************************************
  logic hsync_d;
  logic [vds_pkg::CNT_W-1:0] count_d;
  logic [vds_pkg::CNT_W-1:0] last;
  logic [vds_pkg::CNT_W-1:0] inc2;
  logic [vds_pkg::CNT_W-1:0] start_pos;
  logic [vds_pkg::CNT_W-1:0] stop_pos;

  always_comb
  begin
    last = std_60 ? vds_pkg::LINE_LEN_60 - vds_pkg::CNT_ONE : vds_pkg::LINE_LEN_50 - vds_pkg::CNT_ONE;
    inc2 = count_q + vds_pkg::CNT_TWO;
    start_pos = vds_pkg::delay_pos(vds_pkg::HS_CENTER, start_delay);
    stop_pos = vds_pkg::delay_pos(vds_pkg::HS_CENTER, stop_delay);
    count_d = count_q;
    hsync_d = hsync_q;
    if (llc_en)
    begin
      count_d = (count_q >= last) ? vds_pkg::CNT_ZERO : count_q + vds_pkg::CNT_ONE;
      // Open loop free-runs: line frequency fixed by the counter alone
      if (!loop_open && ref_pulse && count_q != vds_pkg::CNT_ZERO)
      begin
        if (time_const == vds_pkg::HTC_FAST)
          count_d = vds_pkg::CNT_ONE;
        else if (count_q < (last >> 1))
          count_d = count_q;
        else
          count_d = (inc2 > last) ? vds_pkg::CNT_ZERO : inc2;
      end
      if (count_d == start_pos)
        hsync_d = 1'b1;
      else if (count_d == stop_pos)
        hsync_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= vds_pkg::CNT_ZERO;
      hsync_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      hsync_q <= hsync_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_hsync_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(hsync_q) |-> count_q == vds_pkg::delay_pos(vds_pkg::HS_CENTER, $past(start_delay)))
    else $error("hsync rose away from start position");

  a_hsync_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(hsync_q) |-> count_q == vds_pkg::delay_pos(vds_pkg::HS_CENTER, $past(stop_delay)))
    else $error("hsync fell away from stop position");

  sequence s_fast_ref;
    llc_en && ref_pulse && !loop_open && time_const == vds_pkg::HTC_FAST;
  endsequence

  a_fast_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fast_ref |=> count_q == vds_pkg::CNT_ONE)
    else $error("fast lock did not snap counter");

  a_open_loop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    llc_en && loop_open && count_q < (vds_pkg::LINE_LEN_60 - vds_pkg::CNT_ONE)
    |=> count_q == $past(count_q) + vds_pkg::CNT_ONE)
    else $error("open loop counter disturbed");

endmodule

`default_nettype wire

/* File: rtl/vds_sync_ctrl.sv */
/*
  Sync control register bank of the video decoder: start and stop delay of
  the horizontal sync, field standard, odd/even toggling, loop modes.
  Assumes a serial control bus front end that presents subaddress writes and
  reads as one-cycle strobes synchronous to sys_clk.
*/
`default_nettype none

module vds_sync_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register access by subaddress
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Video timing inputs
  input wire logic line_locked_clock_en,
  input wire logic hsync_ref,
  input wire logic field_start,
  input wire logic detected_60hz,
  input wire logic source_interlaced,
  // Sync processing outputs
  output logic hsync_q,
  output logic field_is_60hz_q,
  output logic odd_even_q,
  output logic horiz_loop_open_q,
  output logic [1:0] horiz_time_constant_q,
  output logic [1:0] vert_noise_mode_q
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] hsync_begin_delay_q;
  logic [7:0] hsync_begin_delay_d;
  logic [7:0] hsync_end_delay_q;
  logic [7:0] hsync_end_delay_d;
  logic [7:0] sync_control_q;
  logic [7:0] sync_control_d;
  logic [7:0] reg_rdata_d;
  logic reg_rvalid_d;

  // Delays are stored as written; range limits are left to software
  always_comb
  begin
    hsync_begin_delay_d = hsync_begin_delay_q;
    hsync_end_delay_d = hsync_end_delay_q;
    sync_control_d = sync_control_q;
    reg_rdata_d = reg_rdata_q;
    reg_rvalid_d = reg_rd;
    if (reg_wr)
    begin
      case (reg_addr)
        vds_pkg::ADDR_HS_START: hsync_begin_delay_d = reg_wdata;
        vds_pkg::ADDR_HS_STOP: hsync_end_delay_d = reg_wdata;
        vds_pkg::ADDR_SYNC_CTRL: sync_control_d = reg_wdata;
        default: sync_control_d = sync_control_q;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        vds_pkg::ADDR_HS_START: reg_rdata_d = hsync_begin_delay_q;
        vds_pkg::ADDR_HS_STOP: reg_rdata_d = hsync_end_delay_q;
        vds_pkg::ADDR_SYNC_CTRL: reg_rdata_d = sync_control_q;
        default: reg_rdata_d = vds_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      hsync_begin_delay_q <= vds_pkg::RST_HS_START;
      hsync_end_delay_q <= vds_pkg::RST_HS_STOP;
      sync_control_q <= vds_pkg::RST_SYNC_CTRL;
      reg_rdata_q <= vds_pkg::RDATA_UNMAPPED;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      hsync_begin_delay_q <= hsync_begin_delay_d;
      hsync_end_delay_q <= hsync_end_delay_d;
      sync_control_q <= sync_control_d;
      reg_rdata_q <= reg_rdata_d;
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

  // ****************************************
  // Field standard and odd/even
  // ****************************************
  logic auto_field_detect;
  logic field_standard_select;
  logic forced_field_toggle;
  logic field_is_60hz_d;
  logic odd_even_d;
  logic horiz_loop_open_d;
  logic [1:0] horiz_time_constant_d;
  logic [1:0] vert_noise_mode_d;

  always_comb
  begin
    auto_field_detect = sync_control_q[vds_pkg::BIT_AUTO_FIELD];
    field_standard_select = sync_control_q[vds_pkg::BIT_FIELD_SEL];
    forced_field_toggle = sync_control_q[vds_pkg::BIT_FORCE_TOGGLE];
    field_is_60hz_d = auto_field_detect ? detected_60hz : field_standard_select;
    odd_even_d = odd_even_q;
    // Non-interlaced sources still get alternating fields when forced
    if (field_start && (forced_field_toggle || source_interlaced))
      odd_even_d = ~odd_even_q;
    horiz_loop_open_d = sync_control_q[vds_pkg::BIT_LOOP_OPEN];
    // Reserved time constant code behaves like VTR in the loop filter
    horiz_time_constant_d = sync_control_q[vds_pkg::HTC_HI:vds_pkg::HTC_LO];
    vert_noise_mode_d = sync_control_q[vds_pkg::VERT_NOISE_MODE_HI:vds_pkg::VERT_NOISE_MODE_LO];
  end

  always_ff @(posedge sys_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      field_is_60hz_q <= 1'b0;
      odd_even_q <= 1'b0;
      horiz_loop_open_q <= 1'b0;
      horiz_time_constant_q <= vds_pkg::HTC_FAST;
      vert_noise_mode_q <= vds_pkg::VERT_NOISE_MODE_NORMAL;
    end
    else
    begin
      field_is_60hz_q <= field_is_60hz_d;
      odd_even_q <= odd_even_d;
      horiz_loop_open_q <= horiz_loop_open_d;
      horiz_time_constant_q <= horiz_time_constant_d;
      vert_noise_mode_q <= vert_noise_mode_d;
    end
  end

  // ****************************************
  // Horizontal sync generator
  // ****************************************
  // Registered controls feed the generator: one cycle of lag, cleaner timing
  vds_hsync_gen u_hsync_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_q),
    .llc_en(line_locked_clock_en),
    .std_60(field_is_60hz_q),
    .loop_open(horiz_loop_open_q),
    .time_const(horiz_time_constant_q),
    .start_delay(hsync_begin_delay_q),
    .stop_delay(hsync_end_delay_q),
    .ref_pulse(hsync_ref),
    .hsync_q(hsync_q),
    .count_q()
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_auto_set;
    sync_control_q[vds_pkg::BIT_AUTO_FIELD] ##0 $stable(detected_60hz);
  endsequence

  a_field_auto: assert property (@(posedge sys_clk) disable iff (!rst_q)
    s_auto_set |=> field_is_60hz_q == $past(detected_60hz))
    else $error("auto field standard does not follow detector");

  a_field_forced: assert property (@(posedge sys_clk) disable iff (!rst_q)
    !sync_control_q[vds_pkg::BIT_AUTO_FIELD] |=> field_is_60hz_q == $past(sync_control_q[vds_pkg::BIT_FIELD_SEL]))
    else $error("forced field standard does not follow select bit");

  sequence s_toggle_evt;
    field_start && (sync_control_q[vds_pkg::BIT_FORCE_TOGGLE] || source_interlaced);
  endsequence

  a_toggle_field: assert property (@(posedge sys_clk) disable iff (!rst_q)
    s_toggle_evt |=> odd_even_q != $past(odd_even_q))
    else $error("odd/even did not toggle");

  a_toggle_hold: assert property (@(posedge sys_clk) disable iff (!rst_q)
    !(field_start && (sync_control_q[vds_pkg::BIT_FORCE_TOGGLE] || source_interlaced)) |=> $stable(odd_even_q))
    else $error("odd/even toggled without cause");

  a_loop_mode: assert property (@(posedge sys_clk) disable iff (!rst_q)
    reg_wr && reg_addr == vds_pkg::ADDR_SYNC_CTRL ##1 1'b1 |=> horiz_loop_open_q == $past(reg_wdata[vds_pkg::BIT_LOOP_OPEN], 2))
    else $error("loop mode not taken from write");

  a_tc_noise: assert property (@(posedge sys_clk) disable iff (!rst_q)
    reg_wr && reg_addr == vds_pkg::ADDR_SYNC_CTRL ##2 1'b1
    |-> {horiz_time_constant_q, vert_noise_mode_q} == {$past(reg_wdata[vds_pkg::HTC_HI:vds_pkg::HTC_LO], 2),
        $past(reg_wdata[vds_pkg::VERT_NOISE_MODE_HI:vds_pkg::VERT_NOISE_MODE_LO], 2)})
    else $error("time constant or noise mode not taken from write");

  a_delay_store: assert property (@(posedge sys_clk) disable iff (!rst_q)
    reg_wr && reg_addr == vds_pkg::ADDR_HS_START |=> hsync_begin_delay_q == $past(reg_wdata))
    else $error("start delay not stored");

endmodule

`default_nettype wire

/* File: verification/test_video_decoder_sync_control.sv */
/*
  Self-checking bench for the sync control register bank: register access,
  mode outputs, field logic and horizontal sync placement.
  Assumes vds_pkg is compiled first and a 125 MHz single clock.
*/
`default_nettype none

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end

module test_video_decoder_sync_control;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic line_locked_clock_en = 1'b1;
  logic hsync_ref = 1'b0;
  logic field_start = 1'b0;
  logic detected_60hz = 1'b0;
  logic source_interlaced = 1'b0;
  logic hsync_q;
  logic field_is_60hz_q;
  logic odd_even_q;
  logic horiz_loop_open_q;
  logic [1:0] horiz_time_constant_q;
  logic [1:0] vert_noise_mode_q;
  int n_fail = 0;
  int total_checks = 0;

  vds_sync_ctrl uut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .line_locked_clock_en(line_locked_clock_en), .hsync_ref(hsync_ref), .field_start(field_start),
    .detected_60hz(detected_60hz), .source_interlaced(source_interlaced), .hsync_q(hsync_q),
    .field_is_60hz_q(field_is_60hz_q), .odd_even_q(odd_even_q), .horiz_loop_open_q(horiz_loop_open_q),
    .horiz_time_constant_q(horiz_time_constant_q), .vert_noise_mode_q(vert_noise_mode_q)
  );

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Mode outputs lag the register by one cycle, the write by two
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // Valid stands for one cycle only: look right after the taking edge
    #1;
    `CHK(reg_rvalid_q, 1'b1)
    `CHK(reg_rdata_q, exp)
  endtask

  task automatic wait_lvl(input logic v, output int cnt);
    cnt = 0;
    while (hsync_q !== v && cnt < 3000)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (cnt >= 3000)
      `CHK(hsync_q, v)
  endtask

  // Lines up on a full line after a change, then times pulse and line
  task automatic measure(input logic pulse_ref, output int w, output int p);
    int a;
    int c0;
    c0 = 0;
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, a);
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, a);
    if (pulse_ref)
    begin
      @(posedge sys_clk) hsync_ref <= 1'b1;
      @(posedge sys_clk) hsync_ref <= 1'b0;
      #1;
      c0 = 2;
    end
    wait_lvl(1'b0, a);
    w = a + c0;
    wait_lvl(1'b1, a);
    p = w + a;
  endtask

  task automatic field_pulse();
    @(posedge sys_clk) field_start <= 1'b1;
    @(posedge sys_clk) field_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    int w;
    int p;
    logic prev;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reg_read(8'h06, 8'h00);
    reg_read(8'h07, 8'h00);
    reg_read(8'h08, 8'h98);
    `CHK(horiz_time_constant_q, 2'h3)
    reg_write(8'h09, 8'h5a);
    reg_read(8'h09, 8'h00);
    reg_read(8'h08, 8'h98);
    $display("test reset and map done");

    // Auto detection follows the detector; else the select bit rules
    @(posedge sys_clk) detected_60hz <= 1'b1;
    reg_write(8'h08, 8'h98);
    `CHK(field_is_60hz_q, 1'b1)
    @(posedge sys_clk) detected_60hz <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(field_is_60hz_q, 1'b0)
    reg_write(8'h08, 8'h58);
    `CHK(field_is_60hz_q, 1'b1)
    @(posedge sys_clk) detected_60hz <= 1'b1;
    reg_write(8'h08, 8'h18);
    `CHK(field_is_60hz_q, 1'b0)
    $display("test field standard done");

    prev = odd_even_q;
    @(posedge sys_clk) source_interlaced <= 1'b0;
    field_pulse();
    `CHK(odd_even_q, prev)
    reg_write(8'h08, 8'h38);
    field_pulse();
    `CHK(odd_even_q, ~prev)
    @(posedge sys_clk) source_interlaced <= 1'b1;
    reg_write(8'h08, 8'h18);
    field_pulse();
    `CHK(odd_even_q, prev)
    $display("test odd even done");

    // Every time constant and noise code; auto detect kept clear in all four writes
    for (int i = 0; i < 4; i++)
    begin
      reg_write(8'h08, {3'h0, i[1:0], i[0], i[1:0]});
      `CHK(horiz_time_constant_q, i[1:0])
      `CHK(vert_noise_mode_q, i[1:0])
      `CHK(horiz_loop_open_q, i[0])
      reg_read(8'h08, {3'h0, i[1:0], i[0], i[1:0]});
    end
    $display("test mode codes done");

    // Open loop ignores the reference; 50 Hz lines, then a 60 Hz line
    @(posedge sys_clk) detected_60hz <= 1'b0;
    reg_write(8'h06, 8'hfe);
    reg_write(8'h07, 8'h05);
    reg_write(8'h08, 8'h9c);
    measure(1'b1, w, p);
    `CHK(w, 56)
    `CHK(p, 2048)
    reg_write(8'h06, 8'h94);
    reg_write(8'h07, 8'h6c);
    measure(1'b0, w, p);
    `CHK(w, 1728)
    `CHK(p, 2048)
    @(posedge sys_clk) detected_60hz <= 1'b1;
    reg_write(8'h06, 8'h95);
    reg_write(8'h07, 8'h6b);
    reg_write(8'h08, 8'hdc);
    measure(1'b0, w, p);
    `CHK(w, 1712)
    `CHK(p, 2000)
    // Paused line-locked clock stretches the pulse by the paused cycles
    wait_lvl(1'b1, w);
    @(posedge sys_clk) line_locked_clock_en <= 1'b0;
    repeat (100) @(posedge sys_clk);
    line_locked_clock_en <= 1'b1;
    wait_lvl(1'b0, w);
    `CHK(w + 101, 1812)
    // Closed loop in fast locking: the reference snaps the count to one, so the line restarts late
    reg_write(8'h08, 8'h98);
    measure(1'b1, w, p);
    `CHK(w, 1857)
    `CHK(p, 2145)
    $display("test hsync placement done");
    finish_test();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end
endmodule

`default_nettype wire
